/* rtl/ats_pkg.sv */
package ats_pkg;

    // ****************************************
    // control word layout
    // ****************************************
    localparam int CTRL_W = 16;
    localparam int DIV_SEL_LSB = 14;
    localparam int SMP_SEL_LSB = 12;
    localparam int RESULT_W = 10;
    localparam int SYNC_W = 12;
    localparam int SYNC_BELOW_BIT = 10;
    localparam int SYNC_ABOVE_BIT = 11;

    // ****************************************
    // basic clock divide ratios
    // ****************************************
    localparam logic [4:0] DIV_LEN_00 = 5'h04;
    localparam logic [4:0] DIV_LEN_01 = 5'h02;
    localparam logic [4:0] DIV_LEN_10 = 5'h10;
    localparam logic [4:0] DIV_LEN_11 = 5'h08;

    // ****************************************
    // sample and resolve lengths in basic clocks, load length in clock cycles
    // ****************************************
    localparam logic [6:0] SMP_LEN_00 = 7'h08;
    localparam logic [6:0] SMP_LEN_01 = 7'h10;
    localparam logic [6:0] SMP_LEN_10 = 7'h20;
    localparam logic [6:0] SMP_LEN_11 = 7'h40;
    localparam logic [6:0] RESOLVE_BC = 7'h28;
    localparam logic [1:0] SAR_STEP_LAST = 2'h3;
    localparam logic [1:0] LOAD_LAST = 2'h1;

    // ****************************************
    // result codes and calibration
    // ****************************************
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_FULL = 10'h3FF;
    localparam logic [9:0] SAR_FIRST_BIT = 10'h200;
    localparam int unsigned CAL_BC_PERIODS = 3328;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_RESOLVE, ST_LOAD} ats_phase_t;

    function automatic logic [4:0] ats_div_len(input logic [1:0] sel);
        logic [4:0] len;
        len = DIV_LEN_00;
        unique case (sel)
            2'h0: len = DIV_LEN_00;
            2'h1: len = DIV_LEN_01;
            2'h2: len = DIV_LEN_10;
            2'h3: len = DIV_LEN_11;
        endcase
        return len;
    endfunction : ats_div_len

    function automatic logic [6:0] ats_smp_len(input logic [1:0] sel);
        logic [6:0] len;
        len = SMP_LEN_00;
        unique case (sel)
            2'h0: len = SMP_LEN_00;
            2'h1: len = SMP_LEN_01;
            2'h2: len = SMP_LEN_10;
            2'h3: len = SMP_LEN_11;
        endcase
        return len;
    endfunction : ats_smp_len

endpackage : ats_pkg

/* rtl/ats_bc_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ats_bc_if;
    logic [1:0] div_sel;
    logic restart;
    logic tick;
    modport src (input div_sel, input restart, output tick);
    modport ctl (output div_sel, output restart, input tick);
endinterface : ats_bc_if
`default_nettype wire

/* rtl/ats_bc_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module ats_bc_divider (
    input wire logic clk_i,
    input wire logic rstn_i,
    ats_bc_if.src bc
);
    import ats_pkg::*;

    typedef struct packed {
        logic [4:0] cnt;
    } ats_div_state_t;

    ats_div_state_t st_reg;
    ats_div_state_t st_next;
    logic [4:0] len;

    // ****************************************
    // divider
    // ****************************************
    assign len = ats_div_len(bc.div_sel);
    assign bc.tick = (st_reg.cnt >= (len - 5'h01));

    always_comb
    begin
        st_next = st_reg;
        if (bc.restart || bc.tick)
        begin
            st_next.cnt = 5'h00;
        end
        else
        begin
            st_next.cnt = st_reg.cnt + 5'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_div8_run;
        (bc.div_sel == 2'h3 && !bc.restart)[*8];
    endsequence

    property p_div_quiet;
        @(posedge clk_i) disable iff (!rstn_i)
        (bc.tick && !bc.restart) |=> !bc.tick;
    endproperty
    a_div_quiet: assert property (p_div_quiet) else $error("tick twice in a row");

    property p_div_by8;
        @(posedge clk_i) disable iff (!rstn_i)
        (bc.tick && bc.div_sel == 2'h3 && !bc.restart) ##1 s_div8_run |-> bc.tick;
    endproperty
    a_div_by8: assert property (p_div_by8) else $error("divide by 8 wrong");

endmodule : ats_bc_divider
`default_nettype wire

/* rtl/ats_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module ats_sequencer #(
    parameter int unsigned CAL_PERIODS = ats_pkg::CAL_BC_PERIODS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [ats_pkg::CTRL_W-1:0] converter_control_word_i,
    input wire logic start_i,
    input wire logic [ats_pkg::RESULT_W-1:0] ain_code_i,
    input wire logic ain_below_gnd_i,
    input wire logic ain_above_ref_i,
    output logic sample_o,
    output logic busy_o,
    output logic done_o,
    output logic [ats_pkg::RESULT_W-1:0] result_o,
    output logic cal_busy_o
);
    import ats_pkg::*;

    localparam logic [15:0] CAL_LAST = 16'(CAL_PERIODS - 1);

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [SYNC_W-1:0] hold;
        ats_phase_t phase;
        logic [6:0] bc_cnt;
        logic [1:0] sub_cnt;
        logic [RESULT_W-1:0] mask;
        logic [RESULT_W-1:0] sar;
        logic [1:0] load_cnt;
        logic [15:0] cal_cnt;
        logic cal_busy;
        logic sample;
        logic busy;
        logic done;
        logic [RESULT_W-1:0] result;
    } ats_seq_state_t;

    ats_seq_state_t st_reg;
    ats_seq_state_t st_next;
    logic bc_restart;
    logic [1:0] basic_clock_divider_select;
    logic [1:0] sample_length_select;
    logic [6:0] smp_len;
    logic [RESULT_W-1:0] trial;

    ats_bc_if bc_if();

    // ****************************************
    // basic clock
    // ****************************************
    assign basic_clock_divider_select = converter_control_word_i[DIV_SEL_LSB+1:DIV_SEL_LSB];
    assign sample_length_select = converter_control_word_i[SMP_SEL_LSB+1:SMP_SEL_LSB];
    assign smp_len = ats_smp_len(sample_length_select);
    assign bc_if.div_sel = basic_clock_divider_select;
    assign bc_if.restart = bc_restart;
    assign trial = st_reg.sar | st_reg.mask;

    ats_bc_divider u_div (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .bc(bc_if)
    );

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        st_next = st_reg;
        bc_restart = 1'b0;
        st_next.sync1 = {ain_above_ref_i, ain_below_gnd_i, ain_code_i};
        st_next.sync2 = st_reg.sync1;
        st_next.done = 1'b0;
        if (st_reg.cal_busy && st_reg.phase == ST_IDLE && bc_if.tick)
        begin
            if (st_reg.cal_cnt == CAL_LAST)
            begin
                st_next.cal_busy = 1'b0;
            end
            else
            begin
                st_next.cal_cnt = st_reg.cal_cnt + 16'h0001;
            end
        end
        unique case (st_reg.phase)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    st_next.phase = ST_SAMPLE;
                    st_next.sample = 1'b1;
                    st_next.busy = 1'b1;
                    st_next.bc_cnt = 7'h00;
                    bc_restart = 1'b1;
                end
            end
            ST_SAMPLE:
            begin
                if (bc_if.tick)
                begin
                    if (st_reg.bc_cnt == smp_len - 7'h01)
                    begin
                        st_next.phase = ST_RESOLVE;
                        st_next.sample = 1'b0;
                        st_next.hold = st_reg.sync2;
                        st_next.bc_cnt = 7'h00;
                        st_next.sub_cnt = 2'h0;
                        st_next.mask = SAR_FIRST_BIT;
                        st_next.sar = CODE_ZERO;
                    end
                    else
                    begin
                        st_next.bc_cnt = st_reg.bc_cnt + 7'h01;
                    end
                end
            end
            ST_RESOLVE:
            begin
                if (bc_if.tick)
                begin
                    st_next.sub_cnt = st_reg.sub_cnt + 2'h1;
                    if (st_reg.sub_cnt == SAR_STEP_LAST)
                    begin
                        if (trial <= st_reg.hold[RESULT_W-1:0])
                        begin
                            st_next.sar = trial;
                        end
                        st_next.mask = st_reg.mask >> 1;
                    end
                    if (st_reg.bc_cnt == RESOLVE_BC - 7'h01)
                    begin
                        st_next.phase = ST_LOAD;
                        st_next.load_cnt = 2'h0;
                    end
                    else
                    begin
                        st_next.bc_cnt = st_reg.bc_cnt + 7'h01;
                    end
                end
            end
            ST_LOAD:
            begin
                if (st_reg.load_cnt == LOAD_LAST)
                begin
                    st_next.phase = ST_IDLE;
                    st_next.busy = 1'b0;
                    st_next.done = 1'b1;
                    if (st_reg.hold[SYNC_BELOW_BIT])
                    begin
                        st_next.result = CODE_ZERO;
                    end
                    else if (st_reg.hold[SYNC_ABOVE_BIT])
                    begin
                        st_next.result = CODE_FULL;
                    end
                    else
                    begin
                        st_next.result = st_reg.sar;
                    end
                end
                else
                begin
                    st_next.load_cnt = st_reg.load_cnt + 2'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            st_reg <= '0;
            st_reg.cal_busy <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign sample_o = st_reg.sample;
    assign busy_o = st_reg.busy;
    assign done_o = st_reg.done;
    assign result_o = st_reg.result;
    assign cal_busy_o = st_reg.cal_busy;

    // ****************************************
    // checks
    // ****************************************
    sequence s_conv_start_default;
        $rose(busy_o) && converter_control_word_i[15:12] == 4'h0;
    endsequence

    sequence s_conv_end;
        busy_o ##1 (!busy_o && done_o);
    endsequence

    property p_conv_len;
        @(posedge clk_i) disable iff (!rstn_i)
        s_conv_start_default |-> ##193 s_conv_end;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    property p_sample_len;
        @(posedge clk_i) disable iff (!rstn_i)
        ($rose(sample_o) && converter_control_word_i[15:12] == 4'h1)
            |-> ##63 sample_o ##1 !sample_o;
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample length wrong");

    property p_start_taken;
        @(posedge clk_i) disable iff (!rstn_i)
        (start_i && st_reg.phase == ST_IDLE) |=> (busy_o && sample_o && !done_o);
    endproperty
    a_start_taken: assert property (p_start_taken) else $error("start not taken");

    property p_done_at_end;
        @(posedge clk_i) disable iff (!rstn_i)
        $fell(busy_o) |-> done_o ##1 !done_o;
    endproperty
    a_done_at_end: assert property (p_done_at_end) else $error("done not with busy end");

    property p_freeze;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_reg.phase != ST_IDLE && !sample_o && $past(st_reg.phase) != ST_SAMPLE)
            |-> $stable(st_reg.hold);
    endproperty
    a_freeze: assert property (p_freeze) else $error("held input changed");

    property p_clamp_low;
        @(posedge clk_i) disable iff (!rstn_i)
        (done_o && st_reg.hold[SYNC_BELOW_BIT]) |-> result_o == CODE_ZERO;
    endproperty
    a_clamp_low: assert property (p_clamp_low) else $error("low clamp wrong");

    property p_clamp_high;
        @(posedge clk_i) disable iff (!rstn_i)
        (done_o && !st_reg.hold[SYNC_BELOW_BIT] && st_reg.hold[SYNC_ABOVE_BIT])
            |-> result_o == CODE_FULL;
    endproperty
    a_clamp_high: assert property (p_clamp_high) else $error("high clamp wrong");

    property p_sar_exact;
        @(posedge clk_i) disable iff (!rstn_i)
        (done_o && st_reg.hold[SYNC_ABOVE_BIT:SYNC_BELOW_BIT] == 2'h0)
            |-> result_o == st_reg.hold[RESULT_W-1:0];
    endproperty
    a_sar_exact: assert property (p_sar_exact) else $error("result differs from held input");

    property p_cal_pause;
        @(posedge clk_i) disable iff (!rstn_i)
        (cal_busy_o && busy_o) |=> $stable(st_reg.cal_cnt);
    endproperty
    a_cal_pause: assert property (p_cal_pause) else $error("calibration counted in conversion");

    property p_cal_end;
        @(posedge clk_i) disable iff (!rstn_i)
        $fell(cal_busy_o) |-> ($past(st_reg.cal_cnt) == CAL_LAST && !$past(busy_o));
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("calibration ended early");

endmodule : ats_sequencer
`default_nettype wire

/* rtl/ats_pkg_unused_guard.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* test/ats_ain_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// analog input channel model
// ****************************************
module ats_ain_model (
    input wire logic clk_i,
    input wire logic [9:0] code_set_i,
    input wire logic below_set_i,
    input wire logic above_set_i,
    output logic [9:0] ain_code_o,
    output logic ain_below_gnd_o,
    output logic ain_above_ref_o
);
    // pin levels follow the commanded source each cycle
    always_ff @(posedge clk_i)
    begin
        ain_code_o <= code_set_i;
        ain_below_gnd_o <= below_set_i;
        ain_above_ref_o <= above_set_i;
    end
endmodule : ats_ain_model
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: mismatch %h vs %h", $time, (a), (b)); end end
module testbench;
    import ats_pkg::*;
    // ****************************************
    // stimulus and instances
    // ****************************************
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [15:0] ctrl = 16'h0000;
    logic start_i = 1'b0;
    logic [9:0] m_code = 10'h000;
    logic m_below = 1'b0;
    logic m_above = 1'b0;
    logic [9:0] ain_code;
    logic ain_below;
    logic ain_above;
    logic sample_o;
    logic busy_o;
    logic done_o;
    logic [9:0] result_o;
    logic cal_busy_o;
    int errors = 0;
    int cmp_count = 0;
    int cal_cnt = 0;
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    ats_ain_model model (.clk_i(clk_i), .code_set_i(m_code), .below_set_i(m_below),
        .above_set_i(m_above), .ain_code_o(ain_code), .ain_below_gnd_o(ain_below),
        .ain_above_ref_o(ain_above));
    ats_sequencer #(.CAL_PERIODS(20)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
        .converter_control_word_i(ctrl), .start_i(start_i), .ain_code_i(ain_code),
        .ain_below_gnd_i(ain_below), .ain_above_ref_i(ain_above), .sample_o(sample_o),
        .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .cal_busy_o(cal_busy_o));
    // calibration length in cycles
    always @(posedge clk_i)
    begin
        if (rstn_i === 1'b0)
            cal_cnt = 0;
        else if (cal_busy_o === 1'b1)
            cal_cnt++;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset;
        @(negedge clk_i);
        rstn_i = 1'b0;
        repeat (8) @(negedge clk_i);
        rstn_i = 1'b1;
    endtask : do_reset
    task automatic wait_cal;
        int k;
        for (k = 0; k < 2000 && cal_busy_o !== 1'b0; k++)
            @(negedge clk_i);
        if (cal_busy_o !== 1'b0)
        begin
            errors++;
            tally_and_finish();
        end
    endtask : wait_cal
    task automatic conv(input logic [1:0] dv, input logic [1:0] sm, input logic [9:0] cd,
        input logic bl, input logic ab, input logic [9:0] late, input logic [9:0] expv);
        int n;
        int s;
        int bc;
        int sc;
        int k;
        logic seen;
        n = (dv == 2'h0) ? 4 : (dv == 2'h1) ? 2 : (dv == 2'h2) ? 16 : 8;
        s = 8 << sm;
        @(negedge clk_i);
        ctrl = {dv, sm, 12'h000};
        m_code = cd;
        m_below = bl;
        m_above = ab;
        repeat (4) @(negedge clk_i);
        start_i = 1'b1;
        bc = 0;
        sc = 0;
        seen = 1'b0;
        for (k = 0; k < 3000 && !seen; k++)
        begin
            @(negedge clk_i);
            start_i = (bc == 4);
            if (busy_o === 1'b1)
                bc++;
            if (sample_o === 1'b1)
                sc++;
            if (sc == s * n && sample_o === 1'b0)
                m_code = late;
            if (done_o === 1'b1)
                seen = 1'b1;
        end
        if (!seen)
        begin
            errors++;
            tally_and_finish();
        end
        `CHK(bc, s * n + 40 * n + 2)
        `CHK(sc, s * n)
        `CHK(result_o, expv)
        @(negedge clk_i);
        `CHK({busy_o, done_o}, 2'b00)
    endtask : conv
    task automatic sc_reset_and_cal;
        do_reset();
        `CHK({sample_o, busy_o, done_o, cal_busy_o}, 4'b0001)
        `CHK(result_o, 10'h000)
        wait_cal();
        `CHK(cal_cnt >= 74 && cal_cnt <= 86, 1'b1)
    endtask : sc_reset_and_cal
    task automatic sc_conv_in_cal;
        do_reset();
        conv(2'h0, 2'h0, 10'h1C3, 1'b0, 1'b0, 10'h1C3, 10'h1C3);
        wait_cal();
        `CHK(cal_cnt >= 266 && cal_cnt <= 282, 1'b1)
    endtask : sc_conv_in_cal
    task automatic sc_all_codes;
        int d;
        int m;
        // code 01 gives a 10 MHz basic clock at 20 MHz, above its limit; run only for the ratio
        for (d = 0; d < 4; d++)
            for (m = 0; m < 4; m++)
                conv(d[1:0], m[1:0], {d[1:0], m[1:0], 6'h25}, 1'b0, 1'b0,
                    {d[1:0], m[1:0], 6'h25}, {d[1:0], m[1:0], 6'h25});
    endtask : sc_all_codes
    task automatic sc_range_and_freeze;
        // divider codes 00 and 11 keep the basic clock at 5 and 2.5 MHz
        conv(2'h0, 2'h0, 10'h155, 1'b1, 1'b0, 10'h155, CODE_ZERO);
        conv(2'h0, 2'h0, 10'h155, 1'b0, 1'b1, 10'h155, CODE_FULL);
        conv(2'h0, 2'h0, 10'h155, 1'b1, 1'b1, 10'h155, CODE_ZERO);
        conv(2'h3, 2'h1, 10'h155, 1'b0, 1'b0, 10'h2AA, 10'h155);
    endtask : sc_range_and_freeze
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        sc_reset_and_cal();
        sc_conv_in_cal();
        sc_all_codes();
        sc_range_and_freeze();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
